// file: pkg/emb_defs.svh
`ifndef EMB_DEFS_SVH
`define EMB_DEFS_SVH

// control register a
`define EMB_CTRLA_ENABLE_BIT   7
`define EMB_CTRLA_LIMIT_HI     6
`define EMB_CTRLA_LIMIT_LO     4
`define EMB_CTRLA_UPPER_WS_HI  3
`define EMB_CTRLA_UPPER_WS_LO  2
`define EMB_CTRLA_LOWER_WS_HI  1
`define EMB_CTRLA_LOWER_WS_LO  0
`define EMB_CTRLA_RESET        8'h00
// control register b
`define EMB_CTRLB_KEEPER_BIT   7
`define EMB_CTRLB_MASK_HI      2
`define EMB_CTRLB_MASK_LO      0
`define EMB_CTRLB_RESET        8'h00
// memory map
`define EMB_INT_TOP            16'h21ff
`define EMB_EXT_BASE           16'h2200
// timing
`define EMB_CLK_PERIOD_NS      25
`define EMB_WAIT_MAX_CYC       3'd3

`endif

// file: pkg/emb_pkg.sv
package emb_pkg;
  typedef enum logic [5:0] {
    EMB_IDLE   = 6'b000001,
    EMB_ADDR   = 6'b000010,
    EMB_STROBE = 6'b000100,
    EMB_WAIT   = 6'b001000,
    EMB_HOLD   = 6'b010000,
    EMB_TAIL   = 6'b100000
  } emb_state_e;

  typedef logic [1:0] emb_wait_t;
endpackage : emb_pkg

// file: logic/emb_hi_mask.sv
`timescale 1ns/1ps
`default_nettype none
`include "emb_defs.svh"

// per-pin release of high address lines to normal port use
module emb_hi_mask #(
  parameter int W = 8
) (
  input  wire logic [2:0]   mask_code_i,
  input  wire logic         enable_i,
  input  wire logic [W-1:0] bus_val_i,
  input  wire logic [W-1:0] port_val_i,
  input  wire logic [W-1:0] port_dir_i,
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe_o
);
  logic [W-1:0] released;

  always_comb begin
    released = '0;
    for (int i = 0; i < W; i++) begin
      if (mask_code_i != 3'h0 && i >= W - int'(mask_code_i)) begin
        released[i] = 1'b1;
      end
    end
    for (int i = 0; i < W; i++) begin
      if (enable_i && !released[i]) begin
        pin_o[i]    = bus_val_i[i];
        pin_oe_o[i] = 1'b1;
      end else begin
        pin_o[i]    = port_val_i[i];
        pin_oe_o[i] = port_dir_i[i];
      end
    end
  end
endmodule : emb_hi_mask

`default_nettype wire

// file: logic/emb_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "emb_defs.svh"

module emb_ctrl
  import emb_pkg::*;
#(
  parameter int HI_W = 8
) (
  input  wire logic            ref_clk_i,
  input  wire logic            rst_n_i,
  // configuration
  input  wire logic [7:0]      ext_mem_ctrl_a_i,
  input  wire logic [7:0]      ext_mem_ctrl_b_i,
  // cpu side
  input  wire logic            req_i,
  input  wire logic            we_i,
  input  wire logic [15:0]     addr_i,
  input  wire logic [7:0]      wdata_i,
  input  wire logic            next_ram_i,
  output logic                 ext_o,
  output logic                 busy_o,
  output logic                 rdata_valid_o,
  output logic [7:0]           rdata_o,
  // port fallback settings
  input  wire logic [7:0]      lo_port_val_i,
  input  wire logic [7:0]      lo_port_dir_i,
  input  wire logic [HI_W-1:0] hi_port_val_i,
  input  wire logic [HI_W-1:0] hi_port_dir_i,
  input  wire logic [2:0]      ctl_port_val_i,
  input  wire logic [2:0]      ctl_port_dir_i,
  // pins
  input  wire logic [7:0]      muxed_addr_data_bus_i,
  output logic [7:0]           muxed_addr_data_bus_o,
  output logic [7:0]           muxed_addr_data_bus_oe_o,
  output logic [7:0]           muxed_pullup_o,
  output logic [HI_W-1:0]      high_addr_bus_o,
  output logic [HI_W-1:0]      high_addr_bus_oe_o,
  output logic                 ale_o,
  output logic                 rd_n_o,
  output logic                 wr_n_o,
  output logic [2:0]           ctl_oe_o
);
  import emb_pkg::*;

  typedef struct packed {
    emb_state_e  st;
    logic        ext;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [2:0]  cnt;
    emb_wait_t   ws;
    logic [7:0]  lo_out;
    logic        lo_drive;
    logic [7:0]  keep;
    logic        ale;
    logic        rd;
    logic        wr;
  } emb_state_s;

  emb_state_s q, next_q;

  // ==========================================================
  // configuration decode
  logic       enable;
  logic       keeper_en;
  logic [2:0] sec_limit;
  logic       upper_sector;
  emb_wait_t  sel_ws;
  logic       is_ext;

  assign enable    = ext_mem_ctrl_a_i[`EMB_CTRLA_ENABLE_BIT];
  assign keeper_en = ext_mem_ctrl_b_i[`EMB_CTRLB_KEEPER_BIT];
  assign sec_limit = ext_mem_ctrl_a_i[`EMB_CTRLA_LIMIT_HI:`EMB_CTRLA_LIMIT_LO];

  // limit 0: whole space is one (lower) sector
  assign upper_sector = (sec_limit != 3'h0) && (addr_i[15:13] >= sec_limit);
  assign sel_ws = upper_sector ?
    ext_mem_ctrl_a_i[`EMB_CTRLA_UPPER_WS_HI:`EMB_CTRLA_UPPER_WS_LO] :
    ext_mem_ctrl_a_i[`EMB_CTRLA_LOWER_WS_HI:`EMB_CTRLA_LOWER_WS_LO];

  // disabled: high addresses go nowhere, never wrap to internal
  assign is_ext = enable && (addr_i >= `EMB_EXT_BASE);

  // ==========================================================
  // access sequencer, all timing on the system clock
  always_comb begin
    next_q        = q;
    next_q.rvalid = 1'b0;
    case (q.st)
      EMB_IDLE: begin
        next_q.ale = 1'b0;
        if (req_i && enable) begin
          next_q.ext      = is_ext;
          next_q.we       = we_i;
          next_q.addr     = addr_i;
          next_q.wdata    = wdata_i;
          next_q.ws       = sel_ws;
          next_q.lo_out   = addr_i[7:0];
          next_q.lo_drive = 1'b1;
          next_q.ale      = 1'b1;
          next_q.st       = EMB_ADDR;
        end
      end
      EMB_ADDR: begin
        // latch strobe falls on the same edge that the address leaves the bus
        next_q.ale = 1'b0;
        next_q.cnt = 3'h0;
        if (q.we) begin
          next_q.lo_out = q.wdata;
        end else begin
          next_q.lo_drive = 1'b0;
        end
        next_q.rd = q.ext && !q.we;
        next_q.wr = q.ext && q.we;
        next_q.st = EMB_STROBE;
      end
      EMB_STROBE: begin
        // ws 01/10 stretch by one/two cycles
        if (q.ws != 2'b00 && q.ws != 2'b11 && q.cnt < {1'b0, q.ws}) begin
          next_q.cnt = q.cnt + 3'h1;
        end else if (q.ws == 2'b11 && q.cnt < 3'h2) begin
          next_q.cnt = q.cnt + 3'h1;
        end else begin
          if (!q.we) begin
            next_q.rdata  = q.ext ? muxed_addr_data_bus_i : 8'h00;
            next_q.rvalid = 1'b1;
          end
          next_q.rd = 1'b0;
          next_q.wr = 1'b0;
          next_q.st = (q.ws == 2'b11) ? EMB_HOLD : EMB_TAIL;
        end
      end
      EMB_HOLD: begin
        next_q.st = EMB_TAIL;
      end
      EMB_TAIL: begin
        next_q.lo_drive = 1'b0;
        // trailing latch pulse only ahead of a ram access
        next_q.ale = next_ram_i;
        next_q.st  = EMB_IDLE;
      end
      default: begin
        next_q.st = EMB_IDLE;
      end
    endcase
    if (q.lo_drive) begin
      next_q.keep = q.lo_out;
    end
    if (!enable) begin
      next_q.st       = EMB_IDLE;
      next_q.ale      = 1'b0;
      next_q.rd       = 1'b0;
      next_q.wr       = 1'b0;
      next_q.lo_drive = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q          <= '0;
      q.st       <= EMB_IDLE;
      q.ws       <= 2'b00;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // pin multiplexing
  always_comb begin
    if (enable) begin
      // latch strobe low for whole data phase
      ale_o  = q.ale;
      rd_n_o = !q.rd;
      wr_n_o = !q.wr;
      ctl_oe_o = 3'b111;
      if (q.lo_drive) begin
        muxed_addr_data_bus_o    = q.lo_out;
        muxed_addr_data_bus_oe_o = 8'hff;
      end else if (keeper_en) begin
        muxed_addr_data_bus_o    = q.keep;
        muxed_addr_data_bus_oe_o = 8'h00;
      end else begin
        muxed_addr_data_bus_o    = 8'h00;
        muxed_addr_data_bus_oe_o = 8'h00;
      end
    end else begin
      ale_o  = ctl_port_val_i[0];
      rd_n_o = ctl_port_val_i[1];
      wr_n_o = ctl_port_val_i[2];
      ctl_oe_o = ctl_port_dir_i;
      muxed_addr_data_bus_o    = lo_port_val_i;
      muxed_addr_data_bus_oe_o = lo_port_dir_i;
    end
    // pull-up on any input bit whose port bit is one
    muxed_pullup_o = lo_port_val_i & ~muxed_addr_data_bus_oe_o;
  end

  emb_hi_mask #(
    .W (HI_W)
  ) u_hi_mask (
    .mask_code_i (ext_mem_ctrl_b_i[`EMB_CTRLB_MASK_HI:`EMB_CTRLB_MASK_LO]),
    .enable_i    (enable),
    .bus_val_i   (q.addr[8 +: HI_W]),
    .port_val_i  (hi_port_val_i),
    .port_dir_i  (hi_port_dir_i),
    .pin_o       (high_addr_bus_o),
    .pin_oe_o    (high_addr_bus_oe_o)
  );

  assign ext_o         = q.ext;
  assign busy_o        = (q.st != EMB_IDLE);
  assign rdata_valid_o = q.rvalid;
  assign rdata_o       = q.rdata;
endmodule : emb_ctrl

`default_nettype wire

// file: test/emb_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module emb_ctrl_sva #(
  parameter int HI_W = 8
) (
  input wire logic            ref_clk_i,
  input wire logic            rst_n_i,
  input wire logic [7:0]      ext_mem_ctrl_a_i,
  input wire logic [7:0]      ext_mem_ctrl_b_i,
  input wire logic            req_i,
  input wire logic            we_i,
  input wire logic [15:0]     addr_i,
  input wire logic            busy_o,
  input wire logic            ale_o,
  input wire logic            rd_n_o,
  input wire logic            wr_n_o,
  input wire logic [7:0]      muxed_addr_data_bus_o,
  input wire logic [7:0]      muxed_addr_data_bus_oe_o,
  input wire logic [7:0]      muxed_pullup_o,
  input wire logic [7:0]      lo_port_val_i,
  input wire logic [7:0]      lo_port_dir_i,
  input wire logic [HI_W-1:0] hi_port_dir_i,
  input wire logic [HI_W-1:0] high_addr_bus_oe_o,
  input wire logic [2:0]      ctl_port_dir_i,
  input wire logic [2:0]      ctl_oe_o
);
  wire logic en = ext_mem_ctrl_a_i[7];
  wire logic tk = req_i && !busy_o && en;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========
  // pin behaviour
  int_quiet_a:
    assert property (tk && addr_i < 16'h2200 |-> ##1 (rd_n_o && wr_n_o) [*4])
    else $error("strobe on internal access");
  ext_read_a:
    assert property (tk && !we_i && addr_i >= 16'h2200 |-> ##2 !rd_n_o && wr_n_o)
    else $error("no read strobe");
  ale_addr_a:
    assert property (tk |-> ##1 ale_o && muxed_addr_data_bus_o == $past(addr_i[7:0]) ##1 !ale_o)
    else $error("bad latch address");
  ale_data_a:
    assert property (!(rd_n_o && wr_n_o) |-> !ale_o)
    else $error("latch strobe in data phase");
  bus_own_a:
    assert property (en && ext_mem_ctrl_b_i[2:0] == 3'h0 |-> &high_addr_bus_oe_o && &ctl_oe_o)
    else $error("pins not owned");
  port_back_a:
    assert property (!en |-> muxed_addr_data_bus_oe_o == lo_port_dir_i
      && high_addr_bus_oe_o == hi_port_dir_i && ctl_oe_o == ctl_port_dir_i)
    else $error("port settings ignored");
  off_idle_a:
    assert property (!en |-> ##1 !busy_o)
    else $error("cycle while disabled");
  mask_pins_a:
    assert property (en && ext_mem_ctrl_b_i[2:0] == 3'h2 |-> &high_addr_bus_oe_o[HI_W-3:0]
      && high_addr_bus_oe_o[HI_W-1 -: 2] == hi_port_dir_i[HI_W-1 -: 2])
    else $error("mask pins wrong");
  pullup_on_a:
    assert property (muxed_pullup_o == (lo_port_val_i & ~muxed_addr_data_bus_oe_o))
    else $error("pull-up wrong");
endmodule // emb_ctrl_sva
bind emb_ctrl emb_ctrl_sva #(.HI_W(HI_W)) sva_u (
  .ref_clk_i                (ref_clk_i),
  .rst_n_i                  (rst_n_i),
  .ext_mem_ctrl_a_i         (ext_mem_ctrl_a_i),
  .ext_mem_ctrl_b_i         (ext_mem_ctrl_b_i),
  .req_i                    (req_i),
  .we_i                     (we_i),
  .addr_i                   (addr_i),
  .busy_o                   (busy_o),
  .ale_o                    (ale_o),
  .rd_n_o                   (rd_n_o),
  .wr_n_o                   (wr_n_o),
  .muxed_addr_data_bus_o    (muxed_addr_data_bus_o),
  .muxed_addr_data_bus_oe_o (muxed_addr_data_bus_oe_o),
  .muxed_pullup_o           (muxed_pullup_o),
  .lo_port_val_i            (lo_port_val_i),
  .lo_port_dir_i            (lo_port_dir_i),
  .hi_port_dir_i            (hi_port_dir_i),
  .high_addr_bus_oe_o       (high_addr_bus_oe_o),
  .ctl_port_dir_i           (ctl_port_dir_i),
  .ctl_oe_o                 (ctl_oe_o)
);
`default_nettype wire

// file: test/emb_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module emb_sram_model #(
  parameter int AW = 15
) (
  input  wire logic       ale_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] ad_i,
  input  wire logic [7:0] hi_i,
  output logic      [7:0] d_o
);
  logic [7:0] lat;
  logic [7:0] val = 8'h00;
  logic [7:0] mem [int];
  wire  logic [7:0] ad_late;
  // board delay: latch still sees the address just after the strobe falls
  assign #1 ad_late = ad_i;
  // top address line unconnected
  wire logic [15:0] a = {hi_i, lat} & 16'((32'd1 << AW) - 1);
  always_latch if (ale_i) lat <= ad_late;
  always @(a, ad_i, wr_n_i) if (!wr_n_i) mem[a] = ad_i;
  always @(a, rd_n_i) if (!rd_n_i) val = mem.exists(a) ? mem[a] : a[7:0];
  // released bus shows inverse of last byte
  assign d_o = rd_n_i ? ~val : val;
endmodule // emb_sram_model
`default_nettype wire

// file: test/emb_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module emb_ctrl_bench;
  logic        clk, rst_n, req, we, nr, ext, busy, rv, ale, rdn, wrn, ale_p;
  logic [15:0] addr, rd_cnt, ale_cnt, rv_cnt;
  logic [15:0] cyc = 16'h0;
  logic [7:0]  ca, cb, wd, rdata, lpv, lpd, hpv, hpd, ado, adoe, pu, hao, haoe, md, hi_q;
  logic [2:0]  cpv, cpd, coe;
  int          failures = 0;
  int          cmp_count = 0;
  wire logic [7:0] ad = (ado & adoe) | (md & ~adoe);
  emb_ctrl #(.HI_W(8)) dut_u (
    .ref_clk_i(clk), .rst_n_i(rst_n), .ext_mem_ctrl_a_i(ca), .ext_mem_ctrl_b_i(cb),
    .req_i(req), .we_i(we), .addr_i(addr), .wdata_i(wd), .next_ram_i(nr), .ext_o(ext),
    .busy_o(busy), .rdata_valid_o(rv), .rdata_o(rdata), .lo_port_val_i(lpv),
    .lo_port_dir_i(lpd), .hi_port_val_i(hpv), .hi_port_dir_i(hpd), .ctl_port_val_i(cpv),
    .ctl_port_dir_i(cpd), .muxed_addr_data_bus_i(ad), .muxed_addr_data_bus_o(ado),
    .muxed_addr_data_bus_oe_o(adoe), .muxed_pullup_o(pu), .high_addr_bus_o(hao),
    .high_addr_bus_oe_o(haoe), .ale_o(ale), .rd_n_o(rdn), .wr_n_o(wrn), .ctl_oe_o(coe));
  emb_sram_model mem_u (.ale_i(ale), .rd_n_i(rdn), .wr_n_i(wrn), .ad_i(ad), .hi_i(hao), .d_o(md));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // ==========
  // monitor and helpers
  always @(posedge clk) begin
    cyc++;
    if (!rdn) rd_cnt++;
    if (rv) rv_cnt++;
    if (ale && !ale_p) ale_cnt++;
    if (ale) hi_q = hao;
    ale_p = ale;
    if (cyc == 16'd3000) begin
      failures++;
      $display("Error %0t: cycle limit reached", $time);
      print_verdict;
    end
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    {we, addr, wd, req, rd_cnt, ale_cnt, rv_cnt} = {w, a, d, 1'b1, 48'h0};
    cy(1);
    req = 0;
    while (busy === 1'b1 && n < 20) begin
      cy(1);
      n++;
    end
    if (n >= 20) begin
      failures++;
      $display("Error %0t: access never finished", $time);
    end
  endtask
  // ==========
  // scenarios
  task automatic t_rw;
    {ca, cb} = 16'h8080;
    acc(1, 16'h2200, 8'ha5);
    chk(ext, 1);
    chk(rv_cnt, 0);
    acc(0, 16'h2200, 8'h00);
    chk(rdata, 8'ha5);
    chk(rv_cnt, 1);
    acc(0, 16'h21ff, 8'h00);
    chk(ext, 0);
    chk(rd_cnt, 0);
    chk(ado, 8'hff);
    chk(adoe, 8'h00);
    $display("t_rw done");
  endtask
  task automatic t_wait;
    for (int w = 0; w < 4; w++) begin
      ca = {4'hc, 2'(3 - w), 2'(w)};
      acc(0, 16'h30c3, 8'h00);
      chk(rd_cnt, 16'(1 + w - (w == 3)));
      chk(rdata, 8'hc3);
      acc(0, 16'h90c3, 8'h00);
      chk(rd_cnt, 16'(4 - w - (w == 0)));
    end
    $display("t_wait done");
  endtask
  task automatic t_mask;
    {ca, cb, nr} = 17'h10000;
    acc(1, 16'hc123, 8'h11);
    chk(hi_q, 8'hc1);
    cb = 8'h02;
    acc(1, 16'hc123, 8'h22);
    chk(hi_q, 8'h01);
    $display("t_mask done");
  endtask
  task automatic t_tail;
    {ca, cb, nr} = 17'h10001;
    acc(0, 16'h2200, 8'h00);
    cy(2);
    chk(ale_cnt, 2);
    nr = 0;
    acc(0, 16'h2200, 8'h00);
    cy(2);
    chk(ale_cnt, 1);
    $display("t_tail done");
  endtask
  task automatic t_off;
    ca = 8'h7f;
    acc(0, 16'h9000, 8'h00);
    chk(rd_cnt, 0);
    chk(adoe, lpd);
    chk(rdn, cpv[1]);
    $display("t_off done");
  endtask
  initial begin
    {req, we, nr, ale_p, addr, wd, ca, cb, rd_cnt, ale_cnt, rv_cnt} = '0;
    {lpv, lpd, hpv, hpd, cpv, cpd} = {32'h3c0f00ff, 6'o65};
    rst_n = 0;
    cy(3);
    rst_n = 1;
    t_rw;
    t_wait;
    t_mask;
    t_tail;
    t_off;
    print_verdict;
  end
endmodule // emb_ctrl_bench
`default_nettype wire
